// ===== ccp_top.sv
`timescale 1ns/1ns
`include "ccp_defs.svh"
`default_nettype none
module ccp_top
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [`CCP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic pin_a_in,
   output logic pin_a_out,
   output logic pin_a_oe,
   input wire logic pin_b_def_in,
   output logic pin_b_def_out,
   output logic pin_b_def_oe,
   input wire logic pin_b_alt_in,
   output logic pin_b_alt_out,
   output logic pin_b_alt_oe
);

   // bus handshake
   logic wait_reg;
   logic wait_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic wr;

   // software-visible state
   logic [15:0] value_reg [0:1];
   logic [15:0] value_next [0:1];
   ccp_pkg::unit_ctrl_t ctrl_reg [0:1];
   ccp_pkg::unit_ctrl_t ctrl_next [0:1];
   logic [15:0] cnt_reg [0:1];
   logic [15:0] cnt_next [0:1];
   logic [7:0] per_cnt_reg;
   logic [7:0] per_cnt_next;
   logic [7:0] per_limit_reg;
   logic [7:0] per_limit_next;
   logic [2:0] run_reg;
   logic [2:0] run_next;
   logic pinsel_reg;
   logic pinsel_next;
   logic [`CCP_EVT_W-1:0] status_reg;
   logic [`CCP_EVT_W-1:0] status_next;
   logic [`CCP_EVT_W-1:0] mask_reg;
   logic [`CCP_EVT_W-1:0] mask_next;
   logic irq_reg;
   logic irq_next;

   // pin synchronisers and outputs
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic pa_out_reg;
   logic pa_oe_reg;
   logic pbd_out_reg;
   logic pbd_oe_reg;
   logic pba_out_reg;
   logic pba_oe_reg;

   // unit wiring
   ccp_pkg::unit_evt_t evt [0:1];
   logic unit_out [0:1];
   logic unit_oe [0:1];
   logic unit_in [0:1];
   logic [15:0] unit_count [0:1];
   logic per_wrap;
   logic [1:0] clear_cnt;

   assign wr = avs_write & ~wait_reg;
   assign per_wrap = run_reg[`CCP_RUN_PER_BIT] & (per_cnt_reg == per_limit_reg);

   always_comb
   begin
      unit_in[0] = sync2_reg[0];
      // (R9) pin choice by config bit
      unit_in[1] = pinsel_reg ? sync2_reg[1] : sync2_reg[2];
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_unit
         // (R3) per-unit counter choice
         assign unit_count[gi] = ctrl_reg[gi].timer_sel ? cnt_reg[1] : cnt_reg[0];
         // (R7) identical unit instances
         ccp_unit u_unit
         (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .ctrl(ctrl_reg[gi]),
            .value(value_reg[gi]),
            .count(unit_count[gi]),
            .period_count(per_cnt_reg),
            .period_wrap(per_wrap),
            .pin_in(unit_in[gi]),
            .evt(evt[gi]),
            .pin_out(unit_out[gi]),
            .pin_oe(unit_oe[gi])
         );
      end
   endgenerate

   // (R5) each trigger clears its own counter
   always_comb
   begin
      clear_cnt = 2'h0;
      for (int i = 0; i < 2; i++)
      begin
         if (evt[i].trigger)
            clear_cnt[ctrl_reg[i].timer_sel] = 1'b1;
      end
   end

   // bus answer: waitrequest low one cycle after the request
   always_comb
   begin
      wait_next = ~((avs_read | avs_write) & wait_reg);
      rdata_next = rdata_reg;
      if (avs_read & wait_reg)
      begin
         case (avs_address)
            `CCP_OFS_A_LOW: rdata_next = {24'h000000, value_reg[0][7:0]};
            `CCP_OFS_A_HIGH: rdata_next = {24'h000000, value_reg[0][15:8]};
            `CCP_OFS_A_CTRL: rdata_next = {24'h000000, ctrl_reg[0]};
            `CCP_OFS_B_LOW: rdata_next = {24'h000000, value_reg[1][7:0]};
            `CCP_OFS_B_HIGH: rdata_next = {24'h000000, value_reg[1][15:8]};
            `CCP_OFS_B_CTRL: rdata_next = {24'h000000, ctrl_reg[1]};
            `CCP_OFS_CNT_A: rdata_next = {16'h0000, cnt_reg[0]};
            `CCP_OFS_CNT_B: rdata_next = {16'h0000, cnt_reg[1]};
            `CCP_OFS_PER_CNT: rdata_next = {24'h000000, per_cnt_reg};
            `CCP_OFS_PER_LIMIT: rdata_next = {24'h000000, per_limit_reg};
            `CCP_OFS_RUN: rdata_next = {29'h00000000, run_reg};
            `CCP_OFS_CONFIG: rdata_next = {31'h00000000, pinsel_reg};
            `CCP_OFS_STATUS: rdata_next = {29'h00000000, status_reg};
            `CCP_OFS_MASK: rdata_next = {29'h00000000, mask_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   // units: value, control and time-base counters
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         value_next[i] = value_reg[i];
         ctrl_next[i] = ctrl_reg[i];
         cnt_next[i] = cnt_reg[i];
         if (run_reg[i])
            cnt_next[i] = cnt_reg[i] + 16'h0001;
         // (R4) trigger clears used counter
         if (clear_cnt[i])
            cnt_next[i] = `CCP_CNT_RESET;
      end
      // (R1) unit a byte registers
      if (wr && avs_address == `CCP_OFS_A_LOW && avs_byteenable[0])
         value_next[0][7:0] = avs_writedata[7:0];
      if (wr && avs_address == `CCP_OFS_A_HIGH && avs_byteenable[0])
         value_next[0][15:8] = avs_writedata[7:0];
      // (R8) unit b byte registers
      if (wr && avs_address == `CCP_OFS_B_LOW && avs_byteenable[0])
         value_next[1][7:0] = avs_writedata[7:0];
      if (wr && avs_address == `CCP_OFS_B_HIGH && avs_byteenable[0])
         value_next[1][15:8] = avs_writedata[7:0];
      if (wr && avs_address == `CCP_OFS_A_CTRL && avs_byteenable[0])
         ctrl_next[0] = ccp_pkg::unit_ctrl_t'({3'h0, avs_writedata[4:0]});
      if (wr && avs_address == `CCP_OFS_B_CTRL && avs_byteenable[0])
         ctrl_next[1] = ccp_pkg::unit_ctrl_t'({3'h0, avs_writedata[4:0]});
      // (R10) capture from its own counter
      for (int i = 0; i < 2; i++)
      begin
         if (evt[i].capture)
            value_next[i] = unit_count[i];
      end
      if (wr && avs_address == `CCP_OFS_CNT_A)
      begin
         if (avs_byteenable[0])
            cnt_next[0][7:0] = avs_writedata[7:0];
         if (avs_byteenable[1])
            cnt_next[0][15:8] = avs_writedata[15:8];
      end
      if (wr && avs_address == `CCP_OFS_CNT_B)
      begin
         if (avs_byteenable[0])
            cnt_next[1][7:0] = avs_writedata[7:0];
         if (avs_byteenable[1])
            cnt_next[1][15:8] = avs_writedata[15:8];
      end
   end

   // period counter, config, interrupts
   always_comb
   begin
      per_cnt_next = per_cnt_reg;
      // (R6) shared period for both units
      if (per_wrap)
         per_cnt_next = `CCP_PER_CNT_RESET;
      else if (run_reg[`CCP_RUN_PER_BIT])
         per_cnt_next = per_cnt_reg + 8'h01;
      if (wr && avs_address == `CCP_OFS_PER_CNT && avs_byteenable[0])
         per_cnt_next = avs_writedata[7:0];
      per_limit_next = per_limit_reg;
      if (wr && avs_address == `CCP_OFS_PER_LIMIT && avs_byteenable[0])
         per_limit_next = avs_writedata[7:0];
      run_next = run_reg;
      if (wr && avs_address == `CCP_OFS_RUN && avs_byteenable[0])
         run_next = avs_writedata[2:0];
      pinsel_next = pinsel_reg;
      if (wr && avs_address == `CCP_OFS_CONFIG && avs_byteenable[0])
         pinsel_next = avs_writedata[`CCP_CFG_PINSEL_BIT];
      mask_next = mask_reg;
      if (wr && avs_address == `CCP_OFS_MASK && avs_byteenable[0])
         mask_next = avs_writedata[`CCP_EVT_W-1:0];
      status_next = status_reg;
      if (wr && avs_address == `CCP_OFS_STATUS && avs_byteenable[0])
         status_next = status_reg & ~avs_writedata[`CCP_EVT_W-1:0];
      // new events win over a clear
      status_next[`CCP_EVT_A_BIT] = status_next[`CCP_EVT_A_BIT] | evt[0].capture | evt[0].match;
      status_next[`CCP_EVT_B_BIT] = status_next[`CCP_EVT_B_BIT] | evt[1].capture | evt[1].match;
      status_next[`CCP_EVT_PER_BIT] = status_next[`CCP_EVT_PER_BIT] | per_wrap;
      irq_next = |(status_reg & mask_reg);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         for (int i = 0; i < 2; i++)
         begin
            value_reg[i] <= `CCP_VALUE_RESET;
            ctrl_reg[i] <= ccp_pkg::unit_ctrl_t'(`CCP_CTRL_RESET);
            cnt_reg[i] <= `CCP_CNT_RESET;
         end
         per_cnt_reg <= `CCP_PER_CNT_RESET;
         per_limit_reg <= `CCP_PER_LIMIT_RESET;
         run_reg <= `CCP_RUN_RESET;
         pinsel_reg <= `CCP_PINSEL_RESET;
         status_reg <= `CCP_STATUS_RESET;
         mask_reg <= `CCP_MASK_RESET;
         irq_reg <= 1'b0;
      end
      else
      begin
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         for (int i = 0; i < 2; i++)
         begin
            value_reg[i] <= value_next[i];
            ctrl_reg[i] <= ctrl_next[i];
            cnt_reg[i] <= cnt_next[i];
         end
         per_cnt_reg <= per_cnt_next;
         per_limit_reg <= per_limit_next;
         run_reg <= run_next;
         pinsel_reg <= pinsel_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
      end
   end

   // pins: two-stage sync in, registered mux out
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         pa_out_reg <= 1'b0;
         pa_oe_reg <= 1'b0;
         pbd_out_reg <= 1'b0;
         pbd_oe_reg <= 1'b0;
         pba_out_reg <= 1'b0;
         pba_oe_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= {pin_b_alt_in, pin_b_def_in, pin_a_in};
         sync2_reg <= sync1_reg;
         pa_out_reg <= unit_out[0];
         pa_oe_reg <= unit_oe[0];
         // (R9) unit b on selected pin
         pbd_out_reg <= pinsel_reg & unit_out[1];
         pbd_oe_reg <= pinsel_reg & unit_oe[1];
         pba_out_reg <= ~pinsel_reg & unit_out[1];
         pba_oe_reg <= ~pinsel_reg & unit_oe[1];
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign irq = irq_reg;
   assign pin_a_out = pa_out_reg;
   assign pin_a_oe = pa_oe_reg;
   assign pin_b_def_out = pbd_out_reg;
   assign pin_b_def_oe = pbd_oe_reg;
   assign pin_b_alt_out = pba_out_reg;
   assign pin_b_alt_oe = pba_oe_reg;

endmodule // ccp_top
`default_nettype wire

// ===== ccp_defs.svh
// Behaviour
// (R1) Unit a keeps its 16-bit value as a low byte and a high byte register, each readable and writable.
// (R2) Each unit has its own control register, and only that register picks capture, compare or PWM.
// (R3) In capture each unit takes timebase_counter_a or timebase_counter_b, each unit choosing on its own.
// (R4) A comparing unit may issue a special event trigger that clears the counter it uses as its time base.
// (R5) With both units comparing, each trigger clears the counter serving that unit.
// (R6) PWM runs from period_counter, and both PWM units share its frequency and update at its wrap.
// (R7) Unit b behaves exactly like unit a in capture, compare and PWM.
// (R8) Unit b also keeps its 16-bit value as readable and writable low and high byte registers.
// (R9) A configuration bit picks unit b's pin: set gives the default pin, cleared the alternate pin.
// (R10) A unit in PWM does not disturb the other unit's capture or compare, since the counters differ.
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH

`define CCP_ADDR_W 6
`define CCP_OFS_A_LOW 6'h00
`define CCP_OFS_A_HIGH 6'h04
`define CCP_OFS_A_CTRL 6'h08
`define CCP_OFS_B_LOW 6'h0C
`define CCP_OFS_B_HIGH 6'h10
`define CCP_OFS_B_CTRL 6'h14
`define CCP_OFS_CNT_A 6'h18
`define CCP_OFS_CNT_B 6'h1C
`define CCP_OFS_PER_CNT 6'h20
`define CCP_OFS_PER_LIMIT 6'h24
`define CCP_OFS_RUN 6'h28
`define CCP_OFS_CONFIG 6'h2C
`define CCP_OFS_STATUS 6'h30
`define CCP_OFS_MASK 6'h34

`define CCP_CTRL_TSEL_BIT 4
`define CCP_RUN_CNT_A_BIT 0
`define CCP_RUN_CNT_B_BIT 1
`define CCP_RUN_PER_BIT 2
`define CCP_CFG_PINSEL_BIT 0

`define CCP_EVT_W 3
`define CCP_EVT_A_BIT 0
`define CCP_EVT_B_BIT 1
`define CCP_EVT_PER_BIT 2

`define CCP_VALUE_RESET 16'h0000
`define CCP_CTRL_RESET 8'h00
`define CCP_CNT_RESET 16'h0000
`define CCP_PER_CNT_RESET 8'h00
`define CCP_PER_LIMIT_RESET 8'hFF
`define CCP_RUN_RESET 3'h0
`define CCP_PINSEL_RESET 1'h1
`define CCP_STATUS_RESET 3'h0
`define CCP_MASK_RESET 3'h0

`endif

// ===== ccp_pkg.sv
package ccp_pkg;

   typedef enum logic [3:0] {
      MODE_OFF = 4'h0,
      MODE_CAP_FALL = 4'h4,
      MODE_CAP_RISE = 4'h5,
      MODE_CMP_SET = 4'h8,
      MODE_CMP_CLEAR = 4'h9,
      MODE_CMP_EVENT = 4'hA,
      MODE_CMP_TRIGGER = 4'hB,
      MODE_PWM = 4'hC
   } ccp_mode_t;

   typedef struct packed {
      logic [2:0] spare;
      logic timer_sel;
      ccp_mode_t mode;
   } unit_ctrl_t;

   typedef struct packed {
      logic capture;
      logic match;
      logic trigger;
   } unit_evt_t;

endpackage

// ===== ccp_unit.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_unit
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire ccp_pkg::unit_ctrl_t ctrl,
   input wire logic [15:0] value,
   input wire logic [15:0] count,
   input wire logic [7:0] period_count,
   input wire logic period_wrap,
   input wire logic pin_in,
   output ccp_pkg::unit_evt_t evt,
   output logic pin_out,
   output logic pin_oe
);

   logic pin_prev_reg;
   logic pin_prev_next;
   logic match_prev_reg;
   logic match_prev_next;
   logic [7:0] duty_reg;
   logic [7:0] duty_next;
   logic pin_out_reg;
   logic pin_out_next;
   logic pin_oe_reg;
   logic pin_oe_next;
   ccp_pkg::unit_evt_t evt_next;
   logic rise;
   logic fall;
   logic match_edge;

   always_comb
   begin
      rise = pin_in & ~pin_prev_reg;
      fall = ~pin_in & pin_prev_reg;
      match_edge = (count == value) & ~match_prev_reg;
      pin_prev_next = pin_in;
      match_prev_next = (count == value);
      duty_next = duty_reg;
      pin_out_next = pin_out_reg;
      pin_oe_next = 1'b0;
      evt_next = '0;
      // (R2) mode from own control
      case (ctrl.mode)
         ccp_pkg::MODE_CAP_FALL:
         begin
            evt_next.capture = fall;
            pin_out_next = 1'b0;
         end
         ccp_pkg::MODE_CAP_RISE:
         begin
            evt_next.capture = rise;
            pin_out_next = 1'b0;
         end
         ccp_pkg::MODE_CMP_SET:
         begin
            pin_oe_next = 1'b1;
            evt_next.match = match_edge;
            if (match_edge)
               pin_out_next = 1'b1;
         end
         ccp_pkg::MODE_CMP_CLEAR:
         begin
            pin_oe_next = 1'b1;
            evt_next.match = match_edge;
            if (match_edge)
               pin_out_next = 1'b0;
         end
         ccp_pkg::MODE_CMP_EVENT:
         begin
            evt_next.match = match_edge;
         end
         ccp_pkg::MODE_CMP_TRIGGER:
         begin
            // (R4) special event trigger
            evt_next.match = match_edge;
            evt_next.trigger = match_edge;
         end
         ccp_pkg::MODE_PWM:
         begin
            pin_oe_next = 1'b1;
            // (R6) duty taken at wrap
            if (period_wrap)
            begin
               duty_next = value[7:0];
               pin_out_next = (value[7:0] != 8'h00);
            end
            else if (period_count == duty_reg)
               pin_out_next = 1'b0;
         end
         default:
         begin
            pin_out_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         pin_prev_reg <= 1'b0;
         match_prev_reg <= 1'b0;
         duty_reg <= 8'h00;
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end
      else
      begin
         pin_prev_reg <= pin_prev_next;
         match_prev_reg <= match_prev_next;
         duty_reg <= duty_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   assign evt = evt_next;
   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;

endmodule // ccp_unit
`default_nettype wire

// ===== ccp_sva.sv
`timescale 1ns/1ns
`include "ccp_defs.svh"
`default_nettype none
module ccp_sva
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [`CCP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq,
   input wire logic pin_a_out,
   input wire logic pin_a_oe,
   input wire logic pin_b_def_out,
   input wire logic pin_b_def_oe,
   input wire logic pin_b_alt_out,
   input wire logic pin_b_alt_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic cfg;
   logic [3:0] ma;
   logic [3:0] mb;
   logic [1:0] age;
   logic hit;
   logic req;
   assign hit = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign req = avs_read || avs_write;
   // shadow of mode and pin select, age counts edges since last change
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         cfg <= 1'b1;
         ma <= 4'h0;
         mb <= 4'h0;
         age <= 2'h3;
      end
      else
      begin
         if (hit && avs_address == `CCP_OFS_A_CTRL) ma <= avs_writedata[3:0];
         if (hit && avs_address == `CCP_OFS_B_CTRL) mb <= avs_writedata[3:0];
         if (hit && avs_address == `CCP_OFS_CONFIG) cfg <= avs_writedata[0];
         if (hit && avs_address inside {`CCP_OFS_A_CTRL, `CCP_OFS_B_CTRL, `CCP_OFS_CONFIG}) age <= 2'h0;
         else if (age != 2'h3) age <= age + 2'h1;
      end
   end
   property p_wait_answer;
      req && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("waitrequest not low after request");
   property p_wait_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   property p_wait_idle;
      !req && avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without request");
   property p_unmapped;
      avs_read && !avs_waitrequest && (avs_address > `CCP_OFS_MASK || avs_address[1:0] != 2'h0)
         |-> avs_readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_alt_quiet;
      age == 2'h3 && cfg |-> !pin_b_alt_oe && !pin_b_alt_out;
   endproperty
   a_alt_quiet: assert property (p_alt_quiet) else $error("alternate pin active");
   property p_def_quiet;
      age == 2'h3 && !cfg |-> !pin_b_def_oe && !pin_b_def_out;
   endproperty
   a_def_quiet: assert property (p_def_quiet) else $error("default pin active");
   property p_a_off;
      age == 2'h3 && !(ma[3] && ma <= 4'hC) |-> !pin_a_oe && !pin_a_out;
   endproperty
   a_a_off: assert property (p_a_off) else $error("unit a pin driven");
   property p_b_off;
      age == 2'h3 && !(mb[3] && mb <= 4'hC) |-> !(cfg ? pin_b_def_oe : pin_b_alt_oe);
   endproperty
   a_b_off: assert property (p_b_off) else $error("unit b pin driven");
   c_read: cover property (avs_read && !avs_waitrequest);
   c_drive: cover property ($rose(pin_a_oe));
   c_irq: cover property ($rose(irq));
endmodule // ccp_sva
bind ccp_top ccp_sva chk_u
(
   .clk_sys(clk_sys),
   .nrst(nrst),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .irq(irq),
   .pin_a_out(pin_a_out),
   .pin_a_oe(pin_a_oe),
   .pin_b_def_out(pin_b_def_out),
   .pin_b_def_oe(pin_b_def_oe),
   .pin_b_alt_out(pin_b_alt_out),
   .pin_b_alt_oe(pin_b_alt_oe)
);
`default_nettype wire

// ===== ccp_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_pins_model
(
   input wire logic ext_a,
   input wire logic ext_bd,
   input wire logic ext_ba,
   input wire logic pin_a_out,
   input wire logic pin_a_oe,
   input wire logic pin_b_def_out,
   input wire logic pin_b_def_oe,
   input wire logic pin_b_alt_out,
   input wire logic pin_b_alt_oe,
   output logic pin_a_in,
   output logic pin_b_def_in,
   output logic pin_b_alt_in
);
   // wire level: the block wins while it drives, else the outside source
   assign pin_a_in = pin_a_oe ? pin_a_out : ext_a;
   assign pin_b_def_in = pin_b_def_oe ? pin_b_def_out : ext_bd;
   assign pin_b_alt_in = pin_b_alt_oe ? pin_b_alt_out : ext_ba;
endmodule // ccp_pins_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic ext_a = 1'b0;
   logic ext_bd = 1'b0;
   logic ext_ba = 1'b0;
   logic pin_a_in, pin_a_out, pin_a_oe, pin_b_def_in, pin_b_def_out, pin_b_def_oe;
   logic pin_b_alt_in, pin_b_alt_out, pin_b_alt_oe;
   logic [31:0] rd;
   int n_errors = 0;
   int compares = 0;
   initial forever #5 clk_sys = ~clk_sys;
   ccp_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .pin_a_in(pin_a_in), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_def_in(pin_b_def_in),
      .pin_b_def_out(pin_b_def_out), .pin_b_def_oe(pin_b_def_oe), .pin_b_alt_in(pin_b_alt_in),
      .pin_b_alt_out(pin_b_alt_out), .pin_b_alt_oe(pin_b_alt_oe));
   ccp_pins_model pins_u (.ext_a(ext_a), .ext_bd(ext_bd), .ext_ba(ext_ba), .pin_a_out(pin_a_out),
      .pin_a_oe(pin_a_oe), .pin_b_def_out(pin_b_def_out), .pin_b_def_oe(pin_b_def_oe),
      .pin_b_alt_out(pin_b_alt_out), .pin_b_alt_oe(pin_b_alt_oe), .pin_a_in(pin_a_in),
      .pin_b_def_in(pin_b_def_in), .pin_b_alt_in(pin_b_alt_in));
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0)
      begin
         n_errors++;
         finish_test();
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic t_regs;
      logic [5:0] ofs [4] = '{6'h00, 6'h04, 6'h0C, 6'h10};
      rc(6'h00, 32'h0);
      rc(6'h24, 32'hFF);
      rc(6'h2C, 32'h1);
      for (int i = 0; i < 4; i++) xfer(1'b1, ofs[i], 32'h5A + i);
      for (int i = 0; i < 4; i++) rc(ofs[i], 32'h5A + i);
      xfer(1'b1, 6'h3C, 32'hFF);
      rc(6'h3C, 32'h0);
      rc(6'h02, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_capture;
      xfer(1'b1, 6'h18, 32'h1000);
      xfer(1'b1, 6'h1C, 32'h2000);
      xfer(1'b1, 6'h08, 32'h05);
      xfer(1'b1, 6'h14, 32'h15);
      @(posedge clk_sys);
      ext_a <= 1'b1;
      ext_bd <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rc(6'h04, 32'h10);
      rc(6'h10, 32'h20);
      rc(6'h30, 32'h3);
      check(irq, 1'b0);
      xfer(1'b1, 6'h34, 32'h3);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b1);
      xfer(1'b1, 6'h30, 32'h3);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b0);
      xfer(1'b1, 6'h1C, 32'h3000);
      xfer(1'b1, 6'h2C, 32'h0);
      ext_bd <= 1'b0;
      repeat (6) @(posedge clk_sys);
      ext_bd <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rc(6'h10, 32'h20);
      ext_ba <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rc(6'h10, 32'h30);
      xfer(1'b1, 6'h2C, 32'h1);
      xfer(1'b1, 6'h18, 32'h1100);
      xfer(1'b1, 6'h08, 32'h04);
      ext_a <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rc(6'h04, 32'h11);
      xfer(1'b1, 6'h30, 32'h7);
      $display("test capture done");
   endtask
   task automatic t_compare;
      logic [7:0] md [3] = '{8'h08, 8'h09, 8'h0A};
      logic ex [3] = '{1'b1, 1'b0, 1'b0};
      xfer(1'b1, 6'h00, 32'h10);
      xfer(1'b1, 6'h04, 32'h00);
      for (int i = 0; i < 3; i++)
      begin
         xfer(1'b1, 6'h08, md[i]);
         xfer(1'b1, 6'h18, 32'h0);
         xfer(1'b1, 6'h28, 32'h1);
         repeat (40) @(posedge clk_sys);
         xfer(1'b1, 6'h28, 32'h0);
         check(pin_a_out, ex[i]);
         check(pin_a_oe, md[i] != 8'h0A);
         rc(6'h30, 32'h1);
         xfer(1'b1, 6'h30, 32'h7);
      end
      xfer(1'b1, 6'h08, 32'h0B);
      xfer(1'b1, 6'h14, 32'h1B);
      xfer(1'b1, 6'h0C, 32'h20);
      xfer(1'b1, 6'h10, 32'h00);
      xfer(1'b1, 6'h18, 32'h0);
      xfer(1'b1, 6'h1C, 32'h0);
      xfer(1'b1, 6'h28, 32'h3);
      repeat (100) @(posedge clk_sys);
      xfer(1'b1, 6'h28, 32'h0);
      xfer(1'b0, 6'h18, 32'h0);
      check(32'(rd <= 32'h10), 32'h1);
      xfer(1'b0, 6'h1C, 32'h0);
      check(32'(rd <= 32'h20), 32'h1);
      rc(6'h30, 32'h3);
      xfer(1'b1, 6'h30, 32'h7);
      $display("test compare done");
   endtask
   task automatic pwm_count(input int ea, input int eb);
      int na;
      int nb;
      na = 0;
      nb = 0;
      repeat (32)
      begin
         @(posedge clk_sys);
         na += (pin_a_out === 1'b1);
         nb += (pin_b_def_out === 1'b1);
      end
      check(na, ea);
      if (eb >= 0) check(nb, eb);
   endtask
   task automatic t_pwm;
      xfer(1'b1, 6'h24, 32'h0F);
      xfer(1'b1, 6'h00, 32'h04);
      xfer(1'b1, 6'h0C, 32'h08);
      xfer(1'b1, 6'h08, 32'h0C);
      xfer(1'b1, 6'h14, 32'h0C);
      xfer(1'b1, 6'h28, 32'h4);
      repeat (40) @(posedge clk_sys);
      pwm_count(10, 18);
      check({pin_b_alt_oe, pin_b_def_oe}, 2'h1);
      xfer(1'b1, 6'h14, 32'h1B);
      xfer(1'b1, 6'h0C, 32'h20);
      xfer(1'b1, 6'h1C, 32'h0);
      xfer(1'b1, 6'h30, 32'h7);
      xfer(1'b1, 6'h28, 32'h6);
      repeat (100) @(posedge clk_sys);
      pwm_count(10, -1);
      xfer(1'b1, 6'h28, 32'h0);
      xfer(1'b0, 6'h1C, 32'h0);
      check(32'(rd <= 32'h20), 32'h1);
      rc(6'h30, 32'h6);
      $display("test pwm done");
   endtask
   initial
   begin
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      t_regs();
      t_capture();
      t_compare();
      t_pwm();
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
